// *** common/cache_cfg_pkg.sv ***
// constants and types shared by the cache configuration chain and error log
package cache_cfg_pkg;
  // configuration chain
  localparam int unsigned CHAIN_W    = 36;
  localparam int unsigned GROUP_W    = 6;
  localparam int unsigned NUM_GROUPS = 6;
  localparam logic [2:0]  LAST_BIT   = 3'h5;
  localparam logic [2:0]  LAST_GROUP = 3'h5;

  // error capture layout, least significant field first
  localparam int unsigned SYN_W      = 8;
  localparam int unsigned STAT_W     = 5;
  localparam int unsigned STS_W      = 4;
  localparam int unsigned ADDR_W     = 37;
  localparam int unsigned ADDR_LO    = 6;
  localparam int unsigned L1_ADDR_W  = 14;
  localparam int unsigned SYN1_POS   = 0;
  localparam int unsigned SYN0_POS   = 8;
  localparam int unsigned STAT_POS   = 16;
  localparam int unsigned STS_POS    = 21;
  localparam int unsigned ADDR_POS   = 25;
  localparam int unsigned ERR_GROUPS = 11;
  localparam int unsigned ERR_W      = 66;
  localparam logic [3:0]  LAST_RD    = 4'hA;

  // block state bit positions
  localparam int unsigned STS_PARITY = 3;
  localparam int unsigned STS_VALID  = 2;
  localparam int unsigned STS_DIRTY  = 1;
  localparam int unsigned STS_SHARED = 0;

  // error status codes
  localparam logic [4:0] ST_NONE      = 5'h00;
  localparam logic [4:0] ST_L2_TAG    = 5'h01;
  localparam logic [4:0] ST_DUP_TAG   = 5'h02;
  localparam logic [4:0] ST_DATA_MEM  = 5'h03;
  localparam logic [4:0] ST_DATA_L2   = 5'h04;
  localparam logic [4:0] ST_DATA_L1   = 5'h05;
  localparam logic [4:0] ST_PROBE_L2  = 5'h06;
  localparam logic [4:0] ST_INSTR_MEM = 5'h0B;
  localparam logic [4:0] ST_INSTR_L2  = 5'h0C;
  localparam logic [4:0] ST_DBL_GEN   = 5'h10;
  localparam logic [4:0] ST_DBL_FLAG  = 5'h10;

  // kind of error being reported
  typedef enum logic [3:0] {
    KIND_NONE,
    KIND_L2_TAG,
    KIND_DUP_TAG,
    KIND_DATA_MEM,
    KIND_DATA_L2,
    KIND_DATA_L1,
    KIND_PROBE_L2,
    KIND_INSTR_MEM,
    KIND_INSTR_L2
  } err_kind_t;
endpackage

// *** verif/cache_config_chain_and_error_log_tb.sv ***
// self-checking bench for the configuration chain loader and error capture register
`timescale 1ns/1ps
`default_nettype none
module cache_config_chain_and_error_log_tb;
  logic                     sys_clk = 1'b0;
  logic                     rst = 1'b1;
  logic                     chainWrEn = 1'b0;
  logic [5:0]               chainWrData = 6'h00;
  logic                     memmgmtStallReq = 1'b0;
  logic                     errValid = 1'b0;
  cache_cfg_pkg::err_kind_t errKind = cache_cfg_pkg::KIND_NONE;
  logic                     errDouble = 1'b0;
  logic                     errProbeSel = 1'b0;
  logic                     errChangeToDirty = 1'b0;
  logic [7:0]               errSyndromeHi = 8'h00;
  logic [7:0]               errSyndromeLo = 8'h00;
  logic [3:0]               errBlockState = 4'h0;
  logic [36:0]              errAddr = 37'h0;
  logic                     skewFillSetting = 1'b0;
  logic                     errRdEn = 1'b0;
  logic                     chainWrReady;
  logic                     chainBusy;
  logic                     memmgmtStallReady;
  logic [35:0]              cfgWord;
  logic                     cfgUpdate;
  logic [5:0]               errRdData;
  logic                     errRdValid;
  int                       badCount = 0;
  int                       nCompared = 0;
  int                       cyc = 0;
  logic [35:0]              cfgQ[$];
  logic [5:0]               rdQ[$];

  cache_cfg_chain i_dut (
    .sys_clk(sys_clk), .rst(rst), .chainWrEn(chainWrEn), .chainWrData(chainWrData),
    .chainWrReady(chainWrReady), .chainBusy(chainBusy), .memmgmtStallReq(memmgmtStallReq),
    .memmgmtStallReady(memmgmtStallReady), .cfgWord(cfgWord), .cfgUpdate(cfgUpdate),
    .errValid(errValid), .errKind(errKind), .errDouble(errDouble), .errProbeSel(errProbeSel),
    .errChangeToDirty(errChangeToDirty), .errSyndromeHi(errSyndromeHi),
    .errSyndromeLo(errSyndromeLo), .errBlockState(errBlockState), .errAddr(errAddr),
    .skewFillSetting(skewFillSetting), .errRdEn(errRdEn), .errRdData(errRdData),
    .errRdValid(errRdValid)
  );

  always #5 sys_clk = ~sys_clk;

  task automatic chk(input string what, input logic [65:0] seen, input logic [65:0] exp);
    nCompared++;
    if (seen !== exp) begin
      badCount++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic finalReport();
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // cut a hang short
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      badCount++;
      finalReport();
    end
  end

  // registered outputs settle well before the falling edge
  always @(negedge sys_clk) begin
    if (cfgUpdate === 1'b1) begin
      if (cfgQ.size() == 0) begin
        chk("cfgUpdate without six groups", 1, 0);
      end else begin
        chk("cfgWord", cfgWord, cfgQ.pop_front());
      end
    end
    if (errRdValid === 1'b1) begin
      if (rdQ.size() == 0) begin
        chk("errRdValid without read", 1, 0);
      end else begin
        chk("errRdData", errRdData, rdQ.pop_front());
      end
    end
  end

  function automatic logic [4:0] expStat(input int ki, input logic dbl, p, skew);
    logic [4:0] base [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h0B, 5'h0C};
    logic [4:0] c;
    c = base[ki] | ((ki == 6) ? {4'h0, p} : 5'h00);
    if (dbl && ki != 0) begin
      c = ((ki == 3 || ki == 4 || ki == 7 || ki == 8) && !skew) ? (c | 5'h10) : 5'h10;
    end
    return c;
  endfunction

  // six groups, top group first, held while busy
  task automatic chainLoad(input logic [35:0] v);
    int n;
    int b;
    int s;
    logic [35:0] prev;
    cfgQ.push_back(v);
    @(posedge sys_clk);
    chainWrEn <= 1'b1;
    chainWrData <= v[35:30];
    @(negedge sys_clk);
    prev = cfgWord;
    for (int k = 0; k < 6; k++) begin
      @(posedge sys_clk);
      if (k < 5) begin
        chainWrData <= v[29-6*k -: 6];
      end else begin
        chainWrEn <= 1'b0;
      end
      memmgmtStallReq <= (k == 5);
      n = 0;
      b = 0;
      s = 0;
      do begin
        @(negedge sys_clk);
        n++;
        b += (chainBusy === 1'b1);
        s += (memmgmtStallReady === 1'b0);
      end while (chainWrReady !== 1'b1 && n < 20);
      chk("busy cycles", b, 6);
      chk("stall held cycles", s, 6);
      chk("write spacing", n, 7);
      if (k < 5) begin
        chk("cfgWord before sixth group", cfgWord, prev);
      end
    end
  endtask

  // capture then read groups, some runs wrapping
  task automatic errCase(input int ki, input logic dbl);
    logic [65:0] w;
    logic [36:0] a;
    logic [7:0]  hi;
    logic [7:0]  lo;
    logic [3:0]  bs;
    logic        p;
    logic        ctd;
    logic        skew;
    a = 37'({$urandom(), $urandom()});
    hi = 8'($urandom());
    lo = 8'($urandom());
    p = 1'($urandom());
    ctd = 1'($urandom());
    skew = 1'($urandom());
    // ambiguous block state cases are driven as zero
    bs = ((ki == 3 || ki == 4 || ki == 7 || ki == 8) && !dbl) ? 4'($urandom()) : 4'h0;
    @(posedge sys_clk);
    errValid <= 1'b1;
    errKind <= cache_cfg_pkg::err_kind_t'(ki);
    errDouble <= dbl;
    errProbeSel <= p;
    errChangeToDirty <= ctd;
    errSyndromeHi <= hi;
    errSyndromeLo <= lo;
    errBlockState <= bs;
    errAddr <= a;
    skewFillSetting <= skew;
    @(posedge sys_clk);
    errValid <= 1'b0;
    w = {4'h0, ((ki == 5) ? {23'h0, a[13:0]} : a), bs, expStat(ki, dbl, p, skew),
         (ctd ? 16'h0000 : {lo, hi})};
    for (int g = 0; g < ((ki % 2 == 1) ? 12 : 3); g++) begin
      rdQ.push_back(w[6*(g%11) +: 6]);
      errRdEn <= 1'b1;
      @(posedge sys_clk);
      errRdEn <= 1'b0;
      @(posedge sys_clk);
    end
  endtask

  initial begin
    void'($urandom(93399));
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk("reset cfgWord", cfgWord, 0);
    chk("reset ready", chainWrReady, 1);
    chk("reset stall ready", memmgmtStallReady, 1);
    chk("reset read valid", errRdValid, 0);
    // no other traffic runs while the chain loads
    // first value keeps initialization mode clear
    chainLoad(36'h0_7FBF_FFFD);
    chainLoad(36'({$urandom(), $urandom()}));
    chainLoad(36'({$urandom(), $urandom()}));
    for (int ki = 0; ki < 9; ki++) begin
      errCase(ki, 1'b0);
      errCase(ki, 1'b1);
    end
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("pending notes", cfgQ.size() + rdQ.size(), 0);
    finalReport();
  end
endmodule
`default_nettype wire

// *** verilog/cache_cfg_chain.sv ***
// cache unit configuration chain loader and error capture register
//
// Functional notes
// - each chain data write supplies six chain bits, taken from its top bit down
// - stall write to memory-management status held off until last shift ends
// - error capture register reads six bits per access, least significant first
// - two 8-bit syndromes kept; undefined for change-to-dirty commands
// - status 00000 for no error, 00001 for secondary tag parity error
// - data-stream, duplicate tag and probe error codes as encoded
// - double-bit codes only for stream memory or L2 codes with skew fill clear, else generic 10000
// - block state gives parity, valid, dirty, shared for data or instruction stream memory or L2 codes
// - address bits 6 to 42 of last error; only 6 to 19 for L1 errors
// - chain fields ordered so each field's most significant bit comes first
`timescale 1ns/1ps
`default_nettype none
module cache_cfg_chain (
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  // chain data register writes
  input  wire logic                     chainWrEn,
  input  wire logic [5:0]               chainWrData,
  output logic                          chainWrReady,
  output logic                          chainBusy,
  // stall write to memory-management status register
  input  wire logic                     memmgmtStallReq,
  output logic                          memmgmtStallReady,
  // loaded configuration
  output logic [35:0]                   cfgWord,
  output logic                          cfgUpdate,
  // error report from the cache unit
  input  wire logic                     errValid,
  input  wire cache_cfg_pkg::err_kind_t errKind,
  input  wire logic                     errDouble,
  input  wire logic                     errProbeSel,
  input  wire logic                     errChangeToDirty,
  input  wire logic [7:0]               errSyndromeHi,
  input  wire logic [7:0]               errSyndromeLo,
  input  wire logic [3:0]               errBlockState,
  input  wire logic [36:0]              errAddr,
  input  wire logic                     skewFillSetting,
  // error capture register reads
  input  wire logic                     errRdEn,
  output logic [5:0]                    errRdData,
  output logic                          errRdValid
);
  typedef enum logic [0:0] {PH_IDLE, PH_SHIFT} phase_t;

  typedef struct packed {
    phase_t      phase;
    logic [35:0] chain;
    logic [5:0]  group;
    logic [2:0]  bitCnt;
    logic [2:0]  groupCnt;
    logic [35:0] cfg;
    logic        cfgStrobe;
    logic [65:0] errLog;
    logic [3:0]  rdPtr;
    logic [5:0]  rdData;
    logic        rdValid;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic [4:0]  statCode;
  logic        stsDefined;
  logic [65:0] errWord;
  logic [36:0] addrMasked;
  logic [7:0]  synHi;
  logic [7:0]  synLo;
  logic [3:0]  blockStateBits;
  logic [35:0] chainShifted;

  err_status_enc u_enc (
    .kind            (errKind),
    .isDouble        (errDouble),
    .probeSel        (errProbeSel),
    .skewFillSetting (skewFillSetting),
    .statCode        (statCode),
    .stsDefined      (stsDefined)
  );

  always_comb begin
    addrMasked = errAddr;
    if (errKind == cache_cfg_pkg::KIND_DATA_L1) begin
      addrMasked = {{(cache_cfg_pkg::ADDR_W - cache_cfg_pkg::L1_ADDR_W){1'b0}},
                    errAddr[cache_cfg_pkg::L1_ADDR_W-1:0]};
    end
    synHi = errChangeToDirty ? 8'h00 : errSyndromeHi;
    synLo = errChangeToDirty ? 8'h00 : errSyndromeLo;
    blockStateBits = stsDefined ? errBlockState : 4'h0;
    errWord = {4'h0, addrMasked, blockStateBits, statCode, synLo, synHi};
  end

  // serial shift, top bit of group first
  assign chainShifted = {st_r.chain[34:0], st_r.group[5]};

  always_comb begin
    st_nxt           = st_r;
    st_nxt.cfgStrobe = 1'b0;
    st_nxt.rdValid   = 1'b0;
    case (st_r.phase)
      PH_IDLE: begin
        if (chainWrEn) begin
          st_nxt.group  = chainWrData;
          st_nxt.bitCnt = 3'h0;
          st_nxt.phase  = PH_SHIFT;
        end
      end
      PH_SHIFT: begin
        st_nxt.chain  = chainShifted;
        st_nxt.group  = {st_r.group[4:0], 1'b0};
        st_nxt.bitCnt = st_r.bitCnt + 3'h1;
        if (st_r.bitCnt == cache_cfg_pkg::LAST_BIT) begin
          st_nxt.phase = PH_IDLE;
          if (st_r.groupCnt == cache_cfg_pkg::LAST_GROUP) begin
            st_nxt.groupCnt  = 3'h0;
            st_nxt.cfg       = chainShifted;
            st_nxt.cfgStrobe = 1'b1;
          end else begin
            st_nxt.groupCnt = st_r.groupCnt + 3'h1;
          end
        end
      end
      default: begin
        st_nxt.phase = PH_IDLE;
      end
    endcase
    // new report overwrites; a read in the same cycle sees the old word
    if (errValid) begin
      st_nxt.errLog = errWord;
      st_nxt.rdPtr  = 4'h0;
    end
    if (errRdEn) begin
      st_nxt.rdData  = st_r.errLog[6*st_r.rdPtr +: 6];
      st_nxt.rdValid = 1'b1;
      if (!errValid) begin
        st_nxt.rdPtr = (st_r.rdPtr == cache_cfg_pkg::LAST_RD) ? 4'h0 : st_r.rdPtr + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // writes during a shift are held off, not dropped
  assign chainWrReady      = (st_r.phase == PH_IDLE);
  assign chainBusy         = (st_r.phase == PH_SHIFT);
  assign memmgmtStallReady = (st_r.phase == PH_IDLE);
  assign cfgWord           = st_r.cfg;
  assign cfgUpdate         = st_r.cfgStrobe;
  assign errRdData         = st_r.rdData;
  assign errRdValid        = st_r.rdValid;

  logic wrTaken;
  assign wrTaken = chainWrEn && (st_r.phase == PH_IDLE);

  property p_wr_shift;
    @(posedge sys_clk) disable iff (rst)
      wrTaken |=> chainBusy [*6] ##1 !chainBusy;
  endproperty
  a_wr_shift: assert property (p_wr_shift) else $error("write not shifted in six cycles");

  property p_group_lands;
    @(posedge sys_clk) disable iff (rst)
      wrTaken |-> ##7 (st_r.chain[5:0] == $past(chainWrData, 7));
  endproperty
  a_group_lands: assert property (p_group_lands) else $error("group not at chain bottom");

  property p_cfg_sixth;
    @(posedge sys_clk) disable iff (rst)
      cfgUpdate |-> ($past(st_r.groupCnt) == 3'h5) && (cfgWord == st_r.chain);
  endproperty
  a_cfg_sixth: assert property (p_cfg_sixth) else $error("config applied early");

  property p_stall_hold;
    @(posedge sys_clk) disable iff (rst)
      wrTaken |=> !memmgmtStallReady [*6] ##1 memmgmtStallReady;
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("stall released early");

  property p_rd_first;
    @(posedge sys_clk) disable iff (rst)
      errRdEn && (st_r.rdPtr == 4'h0) |=> errRdValid && (errRdData == $past(st_r.errLog[5:0]));
  endproperty
  a_rd_first: assert property (p_rd_first) else $error("first read not low group");

  property p_rd_wrap;
    @(posedge sys_clk) disable iff (rst)
      errRdEn && !errValid && (st_r.rdPtr == 4'hA) |=> (st_r.rdPtr == 4'h0);
  endproperty
  a_rd_wrap: assert property (p_rd_wrap) else $error("read pointer did not wrap");

  property p_ctd_syn;
    @(posedge sys_clk) disable iff (rst)
      errValid && errChangeToDirty |=> (st_r.errLog[15:0] == 16'h0000);
  endproperty
  a_ctd_syn: assert property (p_ctd_syn) else $error("syndrome kept on change to dirty");

  property p_l2_tag;
    @(posedge sys_clk) disable iff (rst)
      errValid && (errKind == cache_cfg_pkg::KIND_L2_TAG) && !errDouble
        |=> (st_r.errLog[20:16] == 5'h01);
  endproperty
  a_l2_tag: assert property (p_l2_tag) else $error("wrong tag parity code");

  property p_instr_mem;
    @(posedge sys_clk) disable iff (rst)
      errValid && (errKind == cache_cfg_pkg::KIND_INSTR_MEM) && !errDouble
        |=> (st_r.errLog[20:16] == 5'h0B);
  endproperty
  a_instr_mem: assert property (p_instr_mem) else $error("wrong instruction memory code");

  property p_dbl_skew;
    @(posedge sys_clk) disable iff (rst)
      errValid && errDouble && skewFillSetting && (errKind != cache_cfg_pkg::KIND_NONE)
        |=> (st_r.errLog[20:16] == 5'h10);
  endproperty
  a_dbl_skew: assert property (p_dbl_skew) else $error("skewed double not generic");

  property p_l1_addr;
    @(posedge sys_clk) disable iff (rst)
      errValid && (errKind == cache_cfg_pkg::KIND_DATA_L1)
        |=> (st_r.errLog[61:39] == 23'h000000)
            && (st_r.errLog[20:16] == ($past(errDouble) ? 5'h10 : 5'h05));
  endproperty
  a_l1_addr: assert property (p_l1_addr) else $error("L1 address not masked");

  property p_sts_kept;
    @(posedge sys_clk) disable iff (rst)
      errValid && (errKind == cache_cfg_pkg::KIND_DATA_L2)
        |=> (st_r.errLog[24:21] == $past(errBlockState));
  endproperty
  a_sts_kept: assert property (p_sts_kept) else $error("block state lost");
endmodule
`default_nettype wire

// *** verilog/err_status_enc.sv ***
// error status code encoder for the error capture register
`timescale 1ns/1ps
`default_nettype none
module err_status_enc (
  // error description
  input  wire cache_cfg_pkg::err_kind_t kind,
  input  wire logic                     isDouble,
  input  wire logic                     probeSel,
  input  wire logic                     skewFillSetting,
  // encoded result
  output logic [4:0]                    statCode,
  output logic                          stsDefined
);
  always_comb begin
    statCode   = cache_cfg_pkg::ST_NONE;
    stsDefined = 1'b0;
    case (kind)
      cache_cfg_pkg::KIND_L2_TAG:    statCode = cache_cfg_pkg::ST_L2_TAG;
      cache_cfg_pkg::KIND_DUP_TAG:   statCode = cache_cfg_pkg::ST_DUP_TAG;
      cache_cfg_pkg::KIND_DATA_MEM:  statCode = cache_cfg_pkg::ST_DATA_MEM;
      cache_cfg_pkg::KIND_DATA_L2:   statCode = cache_cfg_pkg::ST_DATA_L2;
      cache_cfg_pkg::KIND_DATA_L1:   statCode = cache_cfg_pkg::ST_DATA_L1;
      cache_cfg_pkg::KIND_PROBE_L2:  statCode = cache_cfg_pkg::ST_PROBE_L2 | {4'h0, probeSel};
      cache_cfg_pkg::KIND_INSTR_MEM: statCode = cache_cfg_pkg::ST_INSTR_MEM;
      cache_cfg_pkg::KIND_INSTR_L2:  statCode = cache_cfg_pkg::ST_INSTR_L2;
      default:                       statCode = cache_cfg_pkg::ST_NONE;
    endcase
    stsDefined = (kind == cache_cfg_pkg::KIND_DATA_MEM) || (kind == cache_cfg_pkg::KIND_DATA_L2)
              || (kind == cache_cfg_pkg::KIND_INSTR_MEM) || (kind == cache_cfg_pkg::KIND_INSTR_L2);
    if (isDouble && (kind != cache_cfg_pkg::KIND_NONE)) begin
      if (skewFillSetting || !stsDefined) begin
        statCode = cache_cfg_pkg::ST_DBL_GEN;
      end else begin
        statCode = statCode | cache_cfg_pkg::ST_DBL_FLAG;
      end
    end
  end
endmodule
`default_nettype wire
